// ---- src/prc_pkg.sv ----
package prc_pkg;

    // Control mode of the drive, one-hot
    typedef enum logic [2:0] {
        PRC_MODE_POSITION = 3'b001,
        PRC_MODE_SPEED    = 3'b010,
        PRC_MODE_TORQUE   = 3'b100
    } prc_mode_e;

    // Time base
    localparam int unsigned PRC_CLK_PERIOD_NS = 40;
    localparam int unsigned PRC_TICK_NS       = 100000;
    localparam int unsigned PRC_TICK_CYCLES   = PRC_TICK_NS / PRC_CLK_PERIOD_NS;
    localparam int unsigned PRC_TICK_W        = 12;

    // Setting widths
    localparam int unsigned PRC_ERR_W    = 32;
    localparam int unsigned PRC_WIN_W    = 13;
    localparam int unsigned PRC_SETTLE_W = 16;
    localparam int unsigned PRC_TC_W     = 15;
    localparam int unsigned PRC_FREQ_W   = 9;
    localparam int unsigned PRC_DAMP_W   = 8;
    localparam int unsigned PRC_GEAR_W   = 16;

    // Setting limits and values after reset
    localparam logic [12:0] PRC_WIN_MAX     = 13'h1388;
    localparam logic [12:0] PRC_WIN_RST     = 13'h0064;
    localparam logic [15:0] PRC_SETTLE_MAX  = 16'hEA60;
    localparam logic [15:0] PRC_SETTLE_RST  = 16'h01F4;
    localparam logic [14:0] PRC_TC_RST      = 15'h0000;
    localparam logic [8:0]  PRC_FREQ_MIN    = 9'h032;
    localparam logic [8:0]  PRC_FREQ_MAX    = 9'h1F4;
    localparam logic [8:0]  PRC_FREQ_RST    = 9'h064;
    localparam logic [7:0]  PRC_DAMP_MAX    = 8'hC8;
    localparam logic [7:0]  PRC_DAMP_RST    = 8'h19;
    localparam logic [15:0] PRC_GEAR_MIN    = 16'h0001;
    localparam logic [15:0] PRC_GEAR_RST    = 16'h0001;
    localparam logic [15:0] PRC_SETTLE_SAT  = 16'hFFFF;

    // One motion step with its direction, 1 = reverse
    typedef struct packed {
        logic step;
        logic dir;
    } prc_step_s;

endpackage : prc_pkg

// ---- src/prc_smooth_stage.sv ----
module prc_smooth_stage (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             rst_i,
    // Control
    input  wire logic                             tick_i,
    input  wire logic [prc_pkg::PRC_TC_W-1:0]     tc_i,
    input  wire logic                             clear_i,
    // Steps in and out
    input  wire prc_pkg::prc_step_s               in_i,
    output prc_pkg::prc_step_s                    out_o,
    output logic                                  idle_o
);

    typedef struct packed {
        logic signed [31:0] lag;
        logic signed [39:0] acc;
        prc_pkg::prc_step_s out;
    } prc_stage_s;

    prc_stage_s state_reg;
    prc_stage_s state_next;

    always_comb begin
        logic signed [31:0] lag_v;
        logic signed [39:0] acc_v;
        logic signed [39:0] tc_v;
        lag_v = state_reg.lag;
        acc_v = state_reg.acc;
        tc_v  = $signed({25'h0000000, tc_i});
        state_next = state_reg;
        state_next.out = '{step: 1'b0, dir: state_reg.out.dir};
        if (tc_i == '0) begin
            // Zero time constant passes steps straight through
            state_next.out = in_i;
            lag_v = '0;
            acc_v = '0;
        end else begin
            if (in_i.step) begin
                lag_v = in_i.dir ? lag_v - 32'sh1 : lag_v + 32'sh1;
            end
            // Lag integrated per tick gives an exponential approach
            if (tick_i) begin
                acc_v = acc_v + 40'(lag_v);
            end
            if (acc_v >= tc_v) begin
                state_next.out = '{step: 1'b1, dir: 1'b0};
                acc_v = acc_v - tc_v;
                lag_v = lag_v - 32'sh1;
            end else if (acc_v <= -tc_v) begin
                state_next.out = '{step: 1'b1, dir: 1'b1};
                acc_v = acc_v + tc_v;
                lag_v = lag_v + 32'sh1;
            end
        end
        if (clear_i) begin
            lag_v = '0;
            acc_v = '0;
        end
        state_next.lag = lag_v;
        state_next.acc = acc_v;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign out_o  = state_reg.out;
    assign idle_o = (state_reg.lag == '0) && !state_reg.out.step;

endmodule : prc_smooth_stage

// ---- src/prc_top.sv ----
module prc_top (
    // Clock and reset
    input  wire logic                                SYS_CLK_I,
    input  wire logic                                RST_I,
    // Reference pulse pins from the host
    input  wire logic                                REF_PULSE_I,
    input  wire logic                                REF_DIR_I,
    input  wire logic                                ERROR_CLEAR_INPUT_I,
    // Drive state
    input  wire prc_pkg::prc_mode_e                  CONTROL_MODE_I,
    input  wire logic signed [prc_pkg::PRC_ERR_W-1:0] POSITION_ERROR_I,
    input  wire logic                                SPEED_MATCH_I,
    // Settings
    input  wire logic [prc_pkg::PRC_WIN_W-1:0]       DONE_ERROR_WINDOW_I,
    input  wire logic [prc_pkg::PRC_SETTLE_W-1:0]    DONE_SETTLE_TIME_I,
    input  wire logic                                SMOOTHING_ORDER_SELECT_I,
    input  wire logic [prc_pkg::PRC_TC_W-1:0]        SMOOTHING_TIME_CONSTANT_I,
    input  wire logic                                VIBRATION_SUPPRESS_ENABLE_I,
    input  wire logic [prc_pkg::PRC_FREQ_W-1:0]      VIBRATION_FREQ_SETTING_I,
    input  wire logic [prc_pkg::PRC_DAMP_W-1:0]      VIBRATION_DAMPING_SETTING_I,
    input  wire logic [prc_pkg::PRC_GEAR_W-1:0]      GEAR_NUMERATOR_I,
    input  wire logic [prc_pkg::PRC_GEAR_W-1:0]      GEAR_DENOMINATOR_I,
    // Completion pin
    output logic                                     POSITIONING_DONE_N_O,
    // Smoothed, scaled step stream
    output logic                                     SMOOTH_STEP_O,
    output logic                                     SMOOTH_DIR_O,
    // Vibration suppression settings in force
    output logic                                     VIB_ACTIVE_O,
    output logic [prc_pkg::PRC_FREQ_W-1:0]           VIB_FREQ_O,
    output logic [prc_pkg::PRC_DAMP_W-1:0]           VIB_DAMP_O
);

    localparam int NSTAGE = 2;

    typedef struct packed {
        logic [2:0]                          sync_pulse;
        logic [1:0]                          sync_dir;
        logic [1:0]                          sync_clr;
        logic                                order_2nd;
        logic                                vib_en;
        logic [prc_pkg::PRC_GEAR_W-1:0]      gear_num;
        logic [prc_pkg::PRC_GEAR_W-1:0]      gear_den;
        logic [prc_pkg::PRC_GEAR_W:0]        gear_acc;
        logic                                gear_dir;
        prc_pkg::prc_step_s                  gear_out;
        logic [prc_pkg::PRC_TC_W-1:0]        tc_active;
        logic [prc_pkg::PRC_TICK_W-1:0]      tick_cnt;
        logic                                tick;
        logic [prc_pkg::PRC_SETTLE_W-1:0]    settle_cnt;
        logic                                done_n;
        logic [prc_pkg::PRC_FREQ_W-1:0]      vib_freq;
        logic [prc_pkg::PRC_DAMP_W-1:0]      vib_damp;
        logic                                vib_active;
        logic                                first;
    } prc_top_s;

    prc_top_s                            state_reg;
    prc_top_s                            state_next;
    prc_pkg::prc_step_s                  stage_in  [NSTAGE];
    prc_pkg::prc_step_s                  stage_out [NSTAGE];
    logic [NSTAGE-1:0]                   stage_idle;
    logic [prc_pkg::PRC_TC_W-1:0]        stage_tc  [NSTAGE];
    logic                                pulse_edge;
    logic                                idle;
    logic [prc_pkg::PRC_ERR_W-1:0]       err_abs;
    logic                                in_win;
    logic [prc_pkg::PRC_WIN_W-1:0]       win_lim;
    logic [prc_pkg::PRC_SETTLE_W-1:0]    settle_lim;

    // Second synchroniser stage and its delayed copy feed the edge detector
    assign pulse_edge = state_reg.sync_pulse[1] && !state_reg.sync_pulse[2];

    assign err_abs    = POSITION_ERROR_I[prc_pkg::PRC_ERR_W-1] ? 32'(-POSITION_ERROR_I)
                                                               : 32'(POSITION_ERROR_I);
    assign win_lim    = (DONE_ERROR_WINDOW_I > prc_pkg::PRC_WIN_MAX) ? prc_pkg::PRC_WIN_MAX
                                                                     : DONE_ERROR_WINDOW_I;
    assign settle_lim = (DONE_SETTLE_TIME_I > prc_pkg::PRC_SETTLE_MAX) ? prc_pkg::PRC_SETTLE_MAX
                                                                       : DONE_SETTLE_TIME_I;
    // Error arrives already in reference units from the counter after the gear
    assign in_win     = err_abs < {19'h00000, win_lim};

    // Quiet means nothing pending in the reference path past the first synchroniser stage, and zero position error
    assign idle = !pulse_edge && !state_reg.sync_pulse[1]
                  && (state_reg.gear_acc < {1'b0, state_reg.gear_den})
                  && !state_reg.gear_out.step && (&stage_idle)
                  && (POSITION_ERROR_I == '0);

    always_comb begin
        logic [prc_pkg::PRC_GEAR_W:0] acc_v;
        acc_v = state_reg.gear_acc;
        state_next = state_reg;
        state_next.first      = 1'b0;
        state_next.sync_pulse = {state_reg.sync_pulse[1:0], REF_PULSE_I};
        state_next.sync_dir   = {state_reg.sync_dir[0], REF_DIR_I};
        state_next.sync_clr   = {state_reg.sync_clr[0], ERROR_CLEAR_INPUT_I};

        // Restart-only settings caught on the first cycle after reset
        if (state_reg.first) begin
            state_next.order_2nd = SMOOTHING_ORDER_SELECT_I;
            state_next.vib_en    = VIBRATION_SUPPRESS_ENABLE_I;
            state_next.gear_num  = (GEAR_NUMERATOR_I < prc_pkg::PRC_GEAR_MIN) ? prc_pkg::PRC_GEAR_MIN
                                                                              : GEAR_NUMERATOR_I;
            state_next.gear_den  = (GEAR_DENOMINATOR_I < prc_pkg::PRC_GEAR_MIN) ? prc_pkg::PRC_GEAR_MIN
                                                                                : GEAR_DENOMINATOR_I;
        end

        // Gear: each pulse adds numerator, one step out per denominator
        state_next.gear_out.step = 1'b0;
        if (pulse_edge) begin
            acc_v = acc_v + {1'b0, state_reg.gear_num};
            state_next.gear_dir = state_reg.sync_dir[1];
        end
        if (state_reg.gear_acc >= {1'b0, state_reg.gear_den}) begin
            acc_v = acc_v - {1'b0, state_reg.gear_den};
            state_next.gear_out = '{step: 1'b1, dir: state_reg.gear_dir};
        end
        if (state_reg.sync_clr[1]) begin
            acc_v = '0;
        end
        state_next.gear_acc = acc_v;

        // Time constant only swapped while the path is quiet
        if (idle) begin
            state_next.tc_active = SMOOTHING_TIME_CONSTANT_I;
        end

        // 0.1 ms tick
        state_next.tick = 1'b0;
        if (state_reg.tick_cnt == prc_pkg::PRC_TICK_W'(prc_pkg::PRC_TICK_CYCLES - 1)) begin
            state_next.tick_cnt = '0;
            state_next.tick     = 1'b1;
        end else begin
            state_next.tick_cnt = state_reg.tick_cnt + 12'h001;
        end

        // Settle timer restarts the moment the error leaves the window
        if (!in_win) begin
            state_next.settle_cnt = '0;
        end else if (state_reg.tick && state_reg.settle_cnt != prc_pkg::PRC_SETTLE_SAT) begin
            state_next.settle_cnt = state_reg.settle_cnt + 16'h0001;
        end

        case (CONTROL_MODE_I)
            prc_pkg::PRC_MODE_POSITION: state_next.done_n = !(in_win && state_next.settle_cnt > settle_lim);
            prc_pkg::PRC_MODE_SPEED:    state_next.done_n = !SPEED_MATCH_I;
            prc_pkg::PRC_MODE_TORQUE:   state_next.done_n = 1'b1;
            default:                    state_next.done_n = 1'b1;
        endcase

        // Frequency and damping follow at once, clamped to their ranges
        if (VIBRATION_FREQ_SETTING_I < prc_pkg::PRC_FREQ_MIN) begin
            state_next.vib_freq = prc_pkg::PRC_FREQ_MIN;
        end else if (VIBRATION_FREQ_SETTING_I > prc_pkg::PRC_FREQ_MAX) begin
            state_next.vib_freq = prc_pkg::PRC_FREQ_MAX;
        end else begin
            state_next.vib_freq = VIBRATION_FREQ_SETTING_I;
        end
        state_next.vib_damp = (VIBRATION_DAMPING_SETTING_I > prc_pkg::PRC_DAMP_MAX) ? prc_pkg::PRC_DAMP_MAX
                                                                                    : VIBRATION_DAMPING_SETTING_I;
        state_next.vib_active = state_reg.vib_en
                                && (CONTROL_MODE_I == prc_pkg::PRC_MODE_POSITION
                                    || CONTROL_MODE_I == prc_pkg::PRC_MODE_SPEED);
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_reg            <= '0;
            state_reg.gear_num   <= prc_pkg::PRC_GEAR_RST;
            state_reg.gear_den   <= prc_pkg::PRC_GEAR_RST;
            state_reg.tc_active  <= prc_pkg::PRC_TC_RST;
            state_reg.done_n     <= 1'b1;
            state_reg.vib_freq   <= prc_pkg::PRC_FREQ_RST;
            state_reg.vib_damp   <= prc_pkg::PRC_DAMP_RST;
            state_reg.first      <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Second stage is bypassed for first order, so the chain latency is the same
    genvar g;
    generate
        for (g = 0; g < NSTAGE; g++) begin : g_stage
            if (g == 0) begin : g_src
                assign stage_in[g] = state_reg.gear_out;
                assign stage_tc[g] = state_reg.tc_active;
            end else begin : g_chain
                assign stage_in[g] = stage_out[g-1];
                assign stage_tc[g] = state_reg.order_2nd ? state_reg.tc_active : '0;
            end
            prc_smooth_stage u_stage (
                .clk_i   (SYS_CLK_I),
                .rst_i   (RST_I),
                .tick_i  (state_reg.tick),
                .tc_i    (stage_tc[g]),
                .clear_i (state_reg.sync_clr[1]),
                .in_i    (stage_in[g]),
                .out_o   (stage_out[g]),
                .idle_o  (stage_idle[g])
            );
        end
    endgenerate

    assign POSITIONING_DONE_N_O = state_reg.done_n;
    assign SMOOTH_STEP_O        = stage_out[NSTAGE-1].step;
    assign SMOOTH_DIR_O         = stage_out[NSTAGE-1].dir;
    assign VIB_ACTIVE_O         = state_reg.vib_active;
    assign VIB_FREQ_O           = state_reg.vib_freq;
    assign VIB_DAMP_O           = state_reg.vib_damp;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_pos_out_of_window;
        CONTROL_MODE_I == prc_pkg::PRC_MODE_POSITION && !in_win;
    endsequence

    sequence s_done_high;
        POSITIONING_DONE_N_O;
    endsequence

    AST_LEAVE_WINDOW: assert property (s_pos_out_of_window |=> s_done_high)
        else $error("done stayed low after error left window");

    AST_SETTLE_MET: assert property (
        $past(CONTROL_MODE_I) == prc_pkg::PRC_MODE_POSITION && !POSITIONING_DONE_N_O
        |-> state_reg.settle_cnt > $past(settle_lim) && $past(in_win))
        else $error("done asserted before settle time passed");

    // Once settled, done must follow on the very next edge
    AST_SETTLED_DONE: assert property (
        CONTROL_MODE_I == prc_pkg::PRC_MODE_POSITION && in_win && state_reg.settle_cnt > settle_lim
        |=> !POSITIONING_DONE_N_O)
        else $error("done not asserted after settle time");

    AST_SETTLE_RESTART: assert property (s_pos_out_of_window |=> state_reg.settle_cnt == 16'h0000)
        else $error("settle timer not restarted");

    AST_SPEED_MATCH: assert property (
        CONTROL_MODE_I == prc_pkg::PRC_MODE_SPEED |=> POSITIONING_DONE_N_O == !$past(SPEED_MATCH_I))
        else $error("speed match not shown on done pin");

    AST_TORQUE_HIGH: assert property (
        CONTROL_MODE_I == prc_pkg::PRC_MODE_TORQUE [*2] |-> POSITIONING_DONE_N_O)
        else $error("done pin not high in torque mode");

    AST_ORDER_HELD: assert property (!state_reg.first |=> $stable(state_reg.order_2nd))
        else $error("filter order changed without restart");

    AST_GEAR_HELD: assert property (
        !state_reg.first |=> $stable(state_reg.gear_num) && $stable(state_reg.gear_den))
        else $error("gear ratio changed without restart");

    AST_TC_QUIET: assert property (!idle |=> $stable(state_reg.tc_active))
        else $error("time constant changed while path busy");

    AST_CLEAR_RESIDUE: assert property (state_reg.sync_clr[1] |=> state_reg.gear_acc == '0)
        else $error("gear residue kept through error clear");

    AST_VIB_ACTIVE: assert property (
        !state_reg.first |=> VIB_ACTIVE_O == ($past(state_reg.vib_en)
                             && $past(CONTROL_MODE_I) != prc_pkg::PRC_MODE_TORQUE)
                             && $stable(state_reg.vib_en))
        else $error("suppression active flag wrong");

    AST_VIB_FREQ: assert property (
        VIBRATION_FREQ_SETTING_I >= prc_pkg::PRC_FREQ_MIN && VIBRATION_FREQ_SETTING_I <= prc_pkg::PRC_FREQ_MAX
        |=> VIB_FREQ_O == $past(VIBRATION_FREQ_SETTING_I))
        else $error("frequency setting not applied at once");

    AST_FREQ_CLAMP: assert property (
        VIBRATION_FREQ_SETTING_I < prc_pkg::PRC_FREQ_MIN |=> VIB_FREQ_O == prc_pkg::PRC_FREQ_MIN)
        else $error("frequency below range not clamped");

    AST_VIB_DAMP: assert property (
        VIBRATION_DAMPING_SETTING_I <= prc_pkg::PRC_DAMP_MAX |=> VIB_DAMP_O == $past(VIBRATION_DAMPING_SETTING_I))
        else $error("damping setting not applied at once");

    AST_DAMP_CLAMP: assert property (
        VIBRATION_DAMPING_SETTING_I > prc_pkg::PRC_DAMP_MAX |=> VIB_DAMP_O == prc_pkg::PRC_DAMP_MAX)
        else $error("damping above range not clamped");

    AST_GEAR_STEP: assert property (
        state_reg.gear_acc >= {1'b0, state_reg.gear_den} |=> state_reg.gear_out.step)
        else $error("gear step not issued");

endmodule : prc_top

// ---- tb/prc_host_model.sv ----
module prc_host_model (
    // Clock
    input  wire logic clk_i,
    // Pins toward the drive
    output logic      pulse_o,
    output logic      dir_o,
    output logic      clear_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pulse_o = 1'b0;
        dir_o   = 1'b0;
        clear_o = 1'b0;
    end

    // Direction settles three cycles ahead of the first edge; half sets prompt or slow rate
    task automatic send_train(input int n, input logic d, input int half);
        dir_o = d;
        repeat (3) @(posedge clk_i);
        #2;
        for (int i = 0; i < n; i++) begin
            pulse_o = 1'b1;
            repeat (half) @(posedge clk_i);
            #2;
            pulse_o = 1'b0;
            repeat (half) @(posedge clk_i);
            #2;
        end
    endtask : send_train

    // Only called with the pulse train stopped, so a new constant can be adopted
    task automatic clear_error();
        clear_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #2;
        clear_o = 1'b0;
    endtask : clear_error
endmodule : prc_host_model

// ---- tb/position_reference_conditioning_bench.sv ----
module position_reference_conditioning_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk;
    logic                rst;
    logic                pulse;
    logic                dir;
    logic                clr;
    prc_pkg::prc_mode_e  mode;
    logic signed [31:0]  err;
    logic                match;
    logic [12:0]         win;
    logic [15:0]         settle;
    logic                order;
    logic [14:0]         tc;
    logic                ven;
    logic [8:0]          freq;
    logic [7:0]          damp;
    logic [15:0]         num;
    logic [15:0]         den;
    logic                done_n;
    logic                step;
    logic                step_dir;
    logic                vib_act;
    logic [8:0]          vib_freq;
    logic [7:0]          vib_damp;
    int                  miscompares;
    int                  total_checks;
    int                  steps;
    int                  cycles;
    int                  n;
    int                  e;
    logic                last_dir;

    prc_top u_prc_top (
        .SYS_CLK_I(clk), .RST_I(rst), .REF_PULSE_I(pulse), .REF_DIR_I(dir), .ERROR_CLEAR_INPUT_I(clr),
        .CONTROL_MODE_I(mode), .POSITION_ERROR_I(err), .SPEED_MATCH_I(match),
        .DONE_ERROR_WINDOW_I(win), .DONE_SETTLE_TIME_I(settle), .SMOOTHING_ORDER_SELECT_I(order),
        .SMOOTHING_TIME_CONSTANT_I(tc), .VIBRATION_SUPPRESS_ENABLE_I(ven), .VIBRATION_FREQ_SETTING_I(freq),
        .VIBRATION_DAMPING_SETTING_I(damp), .GEAR_NUMERATOR_I(num), .GEAR_DENOMINATOR_I(den),
        .POSITIONING_DONE_N_O(done_n), .SMOOTH_STEP_O(step), .SMOOTH_DIR_O(step_dir),
        .VIB_ACTIVE_O(vib_act), .VIB_FREQ_O(vib_freq), .VIB_DAMP_O(vib_damp)
    );

    prc_host_model u_prc_host_model (.clk_i(clk), .pulse_o(pulse), .dir_o(dir), .clear_o(clr));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        if (step === 1'b1) begin
            steps++;
            last_dir = step_dir;
        end
        cycles++;
        if (cycles >= 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        total_checks++;
        if (seen !== expected) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : cyc

    function automatic logic [8:0] exp_freq(input int f);
        if (f < 50) return 9'h032;
        if (f > 500) return 9'h1F4;
        return 9'(f);
    endfunction : exp_freq

    function automatic logic [7:0] exp_damp(input int d);
        return (d > 200) ? 8'hC8 : 8'(d);
    endfunction : exp_damp

    // Restart-only settings are held stable across the release
    task automatic do_reset(input logic o, input logic v, input logic [15:0] gn, input logic [15:0] gd);
        order = o;
        ven   = v;
        num   = gn;
        den   = gd;
        rst   = 1'b1;
        cyc(6);
        check({done_n, step, vib_act, vib_freq, vib_damp}, {3'h4, 9'h064, 8'h19});
        rst = 1'b0;
        cyc(3);
    endtask : do_reset

    // Residue carries over, so counts stay exact only for multiples of the denominator
    task automatic run_train(input int k, input logic d, input int gn, input int gd, input int half);
        steps = 0;
        u_prc_host_model.send_train(k, d, half);
        cyc(60);
        check(steps, k * gn / gd);
        check(last_dir, d);
    endtask : run_train

    initial begin
        {clk, rst, match, tc, err, settle} = '0;
        mode = prc_pkg::PRC_MODE_POSITION;
        {win, freq, damp} = {13'h0064, 9'h1FF, 8'hFF};
        void'($urandom(32'h7934));
        do_reset(1'b0, 1'b1, 16'h0003, 16'h0002);
        for (int s = 1; s <= 2; s++) begin
            win    = 13'($urandom_range(1, 5000));
            settle = 16'(s);
            err    = 32'(win) + 32'h7;
            cyc(3);
            check(done_n, 1'b1);
            e   = $urandom_range(0, int'(win) - 1);
            err = (s == 2) ? -e : e;
            cyc(s * 2500 - 10);
            check(done_n, 1'b1);
            cyc(2530);
            check(done_n, 1'b0);
            err = 32'(win);
            cyc(1);
            check(done_n, 1'b1);
        end
        {win, settle, err} = {13'h1FFF, 16'h0000, 32'h1388};
        cyc(2600);
        check(done_n, 1'b1);
        err = 32'h1387;
        cyc(2502);
        check(done_n, 1'b0);
        mode = prc_pkg::PRC_MODE_SPEED;
        for (int i = 0; i < 4; i++) begin
            match = 1'($urandom_range(0, 1));
            cyc(1);
            check(done_n, !match);
            check(vib_act, 1'b1);
        end
        mode = prc_pkg::PRC_MODE_TORQUE;
        {match, err} = {1'b1, 32'h0};
        cyc(2);
        check({done_n, vib_act}, 2'h2);
        mode = prc_pkg::PRC_MODE_POSITION;
        for (int i = 0; i < 6; i++) begin
            n    = (i == 0) ? 49 : (i == 1) ? 50 : $urandom_range(0, 511);
            e    = (i == 0) ? 201 : (i == 1) ? 200 : $urandom_range(0, 255);
            freq = 9'(n);
            damp = 8'(e);
            cyc(2);
            check(vib_freq, exp_freq(n));
            check(vib_damp, exp_damp(e));
        end
        run_train(2 * $urandom_range(2, 10), 1'b0, 3, 2, 3);
        run_train(2 * $urandom_range(2, 10), 1'b1, 3, 2, 6);
        tc = 15'h0064;
        cyc(5);
        steps = 0;
        u_prc_host_model.send_train(6, 1'b0, 3);
        cyc(30);
        check(steps, 0);
        // Lag still pending, so a tiny constant must not be taken yet
        tc = 15'h0001;
        cyc(2600);
        check(steps, 0);
        u_prc_host_model.clear_error();
        cyc(3000);
        check(steps, 0);
        tc = 15'h0000;
        cyc(5);
        run_train(8, 1'b0, 3, 2, 3);
        do_reset(1'b1, 1'b0, 16'h0001, 16'h0001);
        {num, ven} = {16'h0005, 1'b1};
        cyc(2);
        check(vib_act, 1'b0);
        run_train(2 * $urandom_range(2, 10), 1'b1, 1, 1, 3);
        tally_and_finish();
    end
endmodule : position_reference_conditioning_bench
